// File: core/shpg_sleep_power_good.sv
// Overview of operation
// - Power-good low when any rail not OK.
// - Power-good low during supply brownout.
// - Leader role: request, acknowledge starts sleep.
// - Follower role: acknowledge alone starts sleep.
// - Sleep request active high in leader role.
// - Leader role accepts low-power mode input.
// - Switch option turns inrush drive into switch3.
// - Switch option makes sense pin switch3 feedback.
// - Active-low open-drain host reset output.
// - Active-low open-drain memory write protect.
// - Two open-drain external regulator enables.
`timescale 1ns/10ps
`include "shpg_defs.svh"

module shpg_sleep_power_good
    import shpg_pkg::*;
#(
    parameter int NUM_INT_RAILS = `SHPG_NUM_INT_RAILS
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst_b,
    input  wire logic                     sleep_role_select,
    input  wire logic                     load_switch_option_select,
    input  wire logic                     sleep_ack_in,
    input  wire logic                     lowpower_mode_in,
    input  wire logic                     ext_regs_ok_in,
    input  wire logic [NUM_INT_RAILS-1:0] rail_ok,
    input  wire logic                     brownout,
    input  wire logic                     host_reset_req,
    input  wire logic                     write_protect_req,
    input  wire logic                     ext_reg1_on,
    input  wire logic                     ext_reg2_on,
    input  wire logic                     inrush_gate_cmd,
    input  wire logic                     switch3_gate_cmd,
    input  wire logic                     inrush_output_sense,
    input  wire logic                     wake_req,
    output logic                          device_sleep_state,
    output logic                          sleep_request_out,
    output logic                          sleep_request_oe,
    output logic                          power_good_out,
    output logic                          power_good_oe,
    output logic                          host_reset_n_out,
    output logic                          host_reset_n_oe,
    output logic                          write_protect_n_out,
    output logic                          write_protect_n_oe,
    output logic                          ext_reg1_enable,
    output logic                          ext_reg1_enable_oe,
    output logic                          ext_reg2_enable,
    output logic                          ext_reg2_enable_oe,
    output logic                          inrush_gate_drive,
    output logic                          switch3_gate_drive,
    output logic                          switch3_feedback,
    output logic                          inrush_sense_valid,
    output logic                          lowpower_mode_seen
);

    initial begin
        if (NUM_INT_RAILS < 1 || NUM_INT_RAILS > 16) begin
            $error("NUM_INT_RAILS must lie between 1 and 16");
        end
    end

    // Strap decodes: the role decode serves the handshake and the pin drivers, the switch option decode the pin drivers only.
    function automatic logic leader_role(input logic role_sel);
        return role_sel == `SHPG_ROLE_LEADER;
    endfunction

    function automatic logic switch3_mode(input logic option_sel);
        return option_sel == `SHPG_LSW_SWITCH3;
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    shpg_async_in_t async_in;
    shpg_async_in_t sync_in;

    assign async_in = '{sleep_ack: sleep_ack_in, lowpower_mode: lowpower_mode_in,
                        ext_regs_ok: ext_regs_ok_in};

    shpg_sync #(
        .WIDTH    ($bits(shpg_async_in_t))
    ) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in (async_in),
        .sync_out (sync_in)
    );

    // ----------------------------------------------------------------
    // Sleep handshake
    // ----------------------------------------------------------------
    shpg_state_t state_r;
    shpg_state_t state_nxt;
    logic        lpm_r;
    logic        lpm_nxt;

    // The leader only asks for sleep when the connector signals low-power
    // mode; the follower ignores that pin because the board may tie it.
    always_comb begin
        state_nxt = state_r;
        lpm_nxt   = leader_role(sleep_role_select) && sync_in.lowpower_mode;
        case (state_r)
            SHPG_ACTIVE: begin
                if (!leader_role(sleep_role_select)) begin
                    if (sync_in.sleep_ack) begin
                        state_nxt = SHPG_SLEEPING;
                    end
                end else if (lpm_r) begin
                    state_nxt = SHPG_REQUESTING;
                end
            end
            SHPG_REQUESTING: begin
                if (sync_in.sleep_ack) begin
                    state_nxt = SHPG_SLEEPING;
                end else if (!lpm_r) begin
                    state_nxt = SHPG_ACTIVE;
                end
            end
            SHPG_SLEEPING: begin
                // Staying asleep until the acknowledge drops avoids re-entry
                // on a single long acknowledge level.
                if (wake_req && !sync_in.sleep_ack) begin
                    state_nxt = SHPG_ACTIVE;
                end
            end
            default: begin
                state_nxt = SHPG_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= SHPG_ACTIVE;
            lpm_r   <= `SHPG_RST_OFF;
        end else begin
            state_r <= state_nxt;
            lpm_r   <= lpm_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    logic pg_r;
    logic pg_nxt;
    logic rst_n_r;
    logic rst_n_nxt;
    logic wp_n_r;
    logic wp_n_nxt;
    logic en1_r;
    logic en1_nxt;
    logic en2_r;
    logic en2_nxt;
    logic req_r;
    logic req_nxt;
    logic inr_r;
    logic inr_nxt;
    logic sw3_r;
    logic sw3_nxt;
    logic fb_r;
    logic fb_nxt;
    logic sns_r;
    logic sns_nxt;

    always_comb begin
        pg_nxt    = (&rail_ok) && sync_in.ext_regs_ok && !brownout;
        rst_n_nxt = !host_reset_req;
        wp_n_nxt  = !write_protect_req;
        en1_nxt   = ext_reg1_on;
        en2_nxt   = ext_reg2_on;
        req_nxt   = leader_role(sleep_role_select) && (state_nxt == SHPG_REQUESTING);
        inr_nxt   = !switch3_mode(load_switch_option_select) && inrush_gate_cmd;
        sw3_nxt   = switch3_mode(load_switch_option_select) && switch3_gate_cmd;
        fb_nxt    = switch3_mode(load_switch_option_select) && inrush_output_sense;
        sns_nxt   = !switch3_mode(load_switch_option_select) && inrush_output_sense;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pg_r    <= `SHPG_RST_PG;
            rst_n_r <= `SHPG_RST_HOST_RESET_N;
            wp_n_r  <= `SHPG_RST_WP_N;
            en1_r   <= `SHPG_RST_OFF;
            en2_r   <= `SHPG_RST_OFF;
            req_r   <= `SHPG_RST_OFF;
            inr_r   <= `SHPG_RST_OFF;
            sw3_r   <= `SHPG_RST_OFF;
            fb_r    <= `SHPG_RST_OFF;
            sns_r   <= `SHPG_RST_OFF;
        end else begin
            pg_r    <= pg_nxt;
            rst_n_r <= rst_n_nxt;
            wp_n_r  <= wp_n_nxt;
            en1_r   <= en1_nxt;
            en2_r   <= en2_nxt;
            req_r   <= req_nxt;
            inr_r   <= inr_nxt;
            sw3_r   <= sw3_nxt;
            fb_r    <= fb_nxt;
            sns_r   <= sns_nxt;
        end
    end

    // Open-drain pins: the enable is high only while the pin is pulled low.
    assign device_sleep_state  = (state_r == SHPG_SLEEPING);
    assign sleep_request_out   = req_r;
    assign sleep_request_oe    = !req_r;
    assign power_good_out      = pg_r;
    assign power_good_oe       = !pg_r;
    assign host_reset_n_out    = rst_n_r;
    assign host_reset_n_oe     = !rst_n_r;
    assign write_protect_n_out = wp_n_r;
    assign write_protect_n_oe  = !wp_n_r;
    assign ext_reg1_enable     = en1_r;
    assign ext_reg1_enable_oe  = !en1_r;
    assign ext_reg2_enable     = en2_r;
    assign ext_reg2_enable_oe  = !en2_r;
    assign inrush_gate_drive   = inr_r;
    assign switch3_gate_drive  = sw3_r;
    assign switch3_feedback    = fb_r;
    assign inrush_sense_valid  = sns_r;
    assign lowpower_mode_seen  = lpm_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_pg_rail;
        @(posedge core_clk) disable iff (!rst_b)
        !(&rail_ok) |=> !power_good_out;
    endproperty
    a_pg_rail: assert property (p_pg_rail) else $error("power good high with a rail down");

    property p_pg_ext;
        @(posedge core_clk) disable iff (!rst_b)
        !ext_regs_ok_in ##1 !ext_regs_ok_in ##1 !ext_regs_ok_in |=> !power_good_out;
    endproperty
    a_pg_ext: assert property (p_pg_ext) else $error("power good high with external rails down");

    property p_pg_brownout;
        @(posedge core_clk) disable iff (!rst_b)
        brownout |=> !power_good_out && power_good_oe;
    endproperty
    a_pg_brownout: assert property (p_pg_brownout) else $error("power good high in brownout");

    property p_leader_sleep;
        @(posedge core_clk) disable iff (!rst_b)
        (state_r == SHPG_REQUESTING) && sync_in.sleep_ack |=> device_sleep_state;
    endproperty
    a_leader_sleep: assert property (p_leader_sleep) else $error("acknowledge did not start sleep");

    property p_follower_sleep;
        @(posedge core_clk) disable iff (!rst_b)
        sleep_role_select && $stable(sleep_role_select) && (state_r == SHPG_ACTIVE) && sync_in.sleep_ack
            |=> device_sleep_state;
    endproperty
    a_follower_sleep: assert property (p_follower_sleep) else $error("follower did not sleep");

    property p_req_role;
        @(posedge core_clk) disable iff (!rst_b)
        sleep_request_out |-> $past(sleep_role_select) == `SHPG_ROLE_LEADER;
    endproperty
    a_req_role: assert property (p_req_role) else $error("sleep request in follower role");

    property p_req_needs_lpm;
        @(posedge core_clk) disable iff (!rst_b)
        $rose(sleep_request_out) |-> $past(lpm_r);
    endproperty
    a_req_needs_lpm: assert property (p_req_needs_lpm) else $error("request without low-power mode");

    property p_switch_mux;
        @(posedge core_clk) disable iff (!rst_b)
        load_switch_option_select |=> !inrush_gate_drive && !inrush_sense_valid;
    endproperty
    a_switch_mux: assert property (p_switch_mux) else $error("inrush active in switch3 option");

    property p_reset_pin;
        @(posedge core_clk) disable iff (!rst_b)
        host_reset_req |=> !host_reset_n_out && host_reset_n_oe;
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("host reset not asserted");

    property p_wp_pin;
        @(posedge core_clk) disable iff (!rst_b)
        write_protect_req |=> !write_protect_n_out && write_protect_n_oe;
    endproperty
    a_wp_pin: assert property (p_wp_pin) else $error("write protect not asserted");

    property p_en_pins;
        @(posedge core_clk) disable iff (!rst_b)
        ext_reg1_on && !ext_reg2_on |=> ext_reg1_enable && ext_reg2_enable_oe;
    endproperty
    a_en_pins: assert property (p_en_pins) else $error("regulator enables wrong");

    property p_sync_delay;
        @(posedge core_clk) disable iff (!rst_b)
        $rose(sync_in.sleep_ack) |-> $past(sleep_ack_in, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("acknowledge not synchronised");

    c_leader_sleep: cover property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == SHPG_REQUESTING) ##1 device_sleep_state);
    c_follower_sleep: cover property (@(posedge core_clk) disable iff (!rst_b)
        sleep_role_select && $rose(device_sleep_state));
    c_wake: cover property (@(posedge core_clk) disable iff (!rst_b) $fell(device_sleep_state));
    c_pg_drop: cover property (@(posedge core_clk) disable iff (!rst_b) $fell(power_good_out));

endmodule

// File: shared/shpg_defs.svh
`ifndef SHPG_DEFS_SVH
`define SHPG_DEFS_SVH

// Synchroniser depth for asynchronous pin inputs.
`define SHPG_SYNC_STAGES      2
// Number of internal rails watched by the power-good aggregator.
`define SHPG_NUM_INT_RAILS    4
// Sleep role select values.
`define SHPG_ROLE_LEADER      1'b0
`define SHPG_ROLE_FOLLOWER    1'b1
// Load-switch option select values.
`define SHPG_LSW_INRUSH       1'b0
`define SHPG_LSW_SWITCH3      1'b1
// Reset values of the pin drivers (one means the pin is released).
`define SHPG_RST_PG           1'b0
`define SHPG_RST_HOST_RESET_N 1'b0
`define SHPG_RST_WP_N         1'b0
// Reset value of the remaining drivers, flags and sense captures.
`define SHPG_RST_OFF          1'b0

`endif

// File: shared/shpg_pkg.sv
package shpg_pkg;

    typedef enum logic [1:0] {
        SHPG_ACTIVE,
        SHPG_REQUESTING,
        SHPG_SLEEPING
    } shpg_state_t;

    typedef struct packed {
        logic sleep_ack;
        logic lowpower_mode;
        logic ext_regs_ok;
    } shpg_async_in_t;

    // Open-drain pin: output level and enable; enable high pulls the pin low.
    typedef struct packed {
        logic o;
        logic oe;
    } shpg_od_t;

endpackage

// File: core/shpg_sync.sv
`timescale 1ns/10ps
`include "shpg_defs.svh"

module shpg_sync
    import shpg_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    initial begin
        if (WIDTH < 1) begin
            $error("shpg_sync needs at least one bit");
        end
    end

    // The first stage is read only by the second stage.
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;

endmodule

// File: test/shpg_host_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Host controller and board regulators seen from the device pins.
// ----------------------------------------------------------------------------
module shpg_host_model #(
    parameter int ACK_DELAY = 2
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic request_pin,
    input  wire logic en1_pin,
    input  wire logic en2_pin,
    input  wire logic force_ack,
    input  wire logic slow,
    output logic      sleep_ack_in,
    output logic      ext_regs_ok_in
);
    int   wait_r;
    logic ack_r;
    logic ok_r;

    // The acknowledge is withdrawn on the first clock after the request falls, so a stale level lingers only for that cycle or while force_ack is high.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_r <= 0;
            ack_r  <= 1'b0;
            ok_r   <= 1'b0;
        end else begin
            ok_r <= en1_pin & en2_pin;
            if (!request_pin) begin
                wait_r <= 0;
                ack_r  <= 1'b0;
            end else if (wait_r >= (slow ? 4 * ACK_DELAY : ACK_DELAY)) begin
                ack_r <= 1'b1;
            end else begin
                wait_r <= wait_r + 1;
            end
        end
    end

    assign sleep_ack_in   = ack_r | force_ack;
    assign ext_regs_ok_in = ok_r;
endmodule

// File: test/shpg_sleep_power_good_tb.sv
`timescale 1ns/10ps

module shpg_sleep_power_good_tb
    import shpg_pkg::*;
;
    logic       core_clk = 1'b0, rst_b = 1'b0, sleep_role_select = 1'b0, load_switch_option_select = 1'b0;
    logic       sleep_ack_in, lowpower_mode_in = 1'b0, ext_regs_ok_in, brownout = 1'b0;
    logic [3:0] rail_ok = 4'hf;
    logic       host_reset_req = 1'b0, write_protect_req = 1'b0, ext_reg1_on = 1'b1, ext_reg2_on = 1'b1;
    logic       inrush_gate_cmd = 1'b0, switch3_gate_cmd = 1'b0, inrush_output_sense = 1'b0, wake_req = 1'b0;
    logic       device_sleep_state, sleep_request_out, sleep_request_oe, power_good_out, power_good_oe;
    logic       host_reset_n_out, host_reset_n_oe, write_protect_n_out, write_protect_n_oe;
    logic       ext_reg1_enable, ext_reg1_enable_oe, ext_reg2_enable, ext_reg2_enable_oe;
    logic       inrush_gate_drive, switch3_gate_drive, switch3_feedback, inrush_sense_valid, lowpower_mode_seen;
    logic       force_ack = 1'b0, slow = 1'b0;
    logic [15:0] rnd = 16'h0057;
    int         fails = 0, comparisons = 0, cycles = 0, n;

    always #5 core_clk = ~core_clk;

    shpg_sleep_power_good #(.NUM_INT_RAILS(4)) u_shpg_sleep_power_good (
        .core_clk, .rst_b, .sleep_role_select, .load_switch_option_select, .sleep_ack_in, .lowpower_mode_in,
        .ext_regs_ok_in, .rail_ok, .brownout, .host_reset_req, .write_protect_req, .ext_reg1_on, .ext_reg2_on,
        .inrush_gate_cmd, .switch3_gate_cmd, .inrush_output_sense, .wake_req, .device_sleep_state,
        .sleep_request_out, .sleep_request_oe, .power_good_out, .power_good_oe, .host_reset_n_out,
        .host_reset_n_oe, .write_protect_n_out, .write_protect_n_oe, .ext_reg1_enable, .ext_reg1_enable_oe,
        .ext_reg2_enable, .ext_reg2_enable_oe, .inrush_gate_drive, .switch3_gate_drive, .switch3_feedback,
        .inrush_sense_valid, .lowpower_mode_seen
    );

    // Open-drain pins read high through their pull-ups whenever the enable is low.
    shpg_host_model #(.ACK_DELAY(2)) u_shpg_host_model (
        .core_clk(core_clk), .rst_b(rst_b), .request_pin(!sleep_request_oe), .en1_pin(!ext_reg1_enable_oe),
        .en2_pin(!ext_reg2_enable_oe), .force_ack(force_ack), .slow(slow), .sleep_ack_in(sleep_ack_in),
        .ext_regs_ok_in(ext_regs_ok_in)
    );

    // ------------------------------------------------------------------------
    // Expectation helpers and reporting.
    // ------------------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic exp_pg(input logic [3:0] r, input logic b);
        return (&r) & !b;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic role);
        @(negedge core_clk);
        rst_b = 1'b0;
        sleep_role_select = role;
        repeat (2) @(negedge core_clk);
        check(host_reset_n_oe, 1'b1);
        check(write_protect_n_oe, 1'b1);
        check(power_good_out, 1'b0);
        rst_b = 1'b1;
        repeat (6) @(negedge core_clk);
    endtask

    task automatic wake_up;
        for (n = 0; n < 20 && sleep_ack_in; n++) @(negedge core_clk);
        repeat (4) @(negedge core_clk);
        wake_req = 1'b1;
        for (n = 0; n < 10 && device_sleep_state; n++) @(negedge core_clk);
        wake_req = 1'b0;
        check(device_sleep_state, 1'b0);
    endtask

    task automatic leader_sleep(input logic s);
        slow = s;
        lowpower_mode_in = 1'b1;
        repeat (2) @(negedge core_clk);
        check(lowpower_mode_seen, 1'b0);
        @(negedge core_clk);
        check(lowpower_mode_seen, 1'b1);
        check(sleep_request_out, 1'b0);
        @(negedge core_clk);
        check(sleep_request_out, 1'b1);
        check(sleep_request_oe, 1'b0);
        for (n = 0; n < 20 && !sleep_ack_in; n++) @(negedge core_clk);
        repeat (2) @(negedge core_clk);
        check(device_sleep_state, 1'b0);
        @(negedge core_clk);
        check(device_sleep_state, 1'b1);
        check(sleep_request_out, 1'b0);
        lowpower_mode_in = 1'b0;
        wake_up();
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_sim();
        end
    end

    // ------------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------------
    initial begin
        do_reset(1'b0);
        for (int opt = 0; opt < 2; opt++) begin
            load_switch_option_select = opt[0];
            for (int i = 0; i < 40; i++) begin
                rnd = lfsr(rnd);
                rail_ok = rnd[15] ? 4'hf : rnd[3:0];
                brownout = rnd[4] & rnd[14];
                host_reset_req = rnd[5];
                write_protect_req = rnd[6];
                inrush_gate_cmd = rnd[7];
                switch3_gate_cmd = rnd[8];
                inrush_output_sense = rnd[9];
                @(negedge core_clk);
                check(power_good_out, exp_pg(rail_ok, brownout));
                check(power_good_oe, !exp_pg(rail_ok, brownout));
                check(host_reset_n_out, !host_reset_req);
                check(host_reset_n_oe, host_reset_req);
                check(write_protect_n_out, !write_protect_req);
                check(write_protect_n_oe, write_protect_req);
                check({ext_reg1_enable, ext_reg1_enable_oe}, 2'h2);
                check({ext_reg2_enable, ext_reg2_enable_oe}, 2'h2);
                check(inrush_gate_drive, !opt[0] & inrush_gate_cmd);
                check(switch3_gate_drive, opt[0] & switch3_gate_cmd);
                check(switch3_feedback, opt[0] & inrush_output_sense);
                check(inrush_sense_valid, !opt[0] & inrush_output_sense);
                check(device_sleep_state, 1'b0);
            end
        end
        rail_ok = 4'hf;
        brownout = 1'b0;
        ext_reg2_on = 1'b0;
        repeat (6) @(negedge core_clk);
        check({ext_reg2_enable, ext_reg2_enable_oe}, 2'h1);
        check(power_good_out, 1'b0);
        ext_reg2_on = 1'b1;
        repeat (6) @(negedge core_clk);
        check(power_good_out, 1'b1);
        ext_reg1_on = 1'b0;
        repeat (6) @(negedge core_clk);
        check({ext_reg1_enable, ext_reg1_enable_oe}, 2'h1);
        check(power_good_out, 1'b0);
        ext_reg1_on = 1'b1;
        repeat (6) @(negedge core_clk);
        check(power_good_out, 1'b1);
        force_ack = 1'b1;
        repeat (6) @(negedge core_clk);
        check(device_sleep_state, 1'b0);
        force_ack = 1'b0;
        repeat (4) @(negedge core_clk);
        // A low-power request withdrawn before the slow acknowledge leaves the device awake.
        slow = 1'b1;
        lowpower_mode_in = 1'b1;
        repeat (4) @(negedge core_clk);
        check(sleep_request_out, 1'b1);
        lowpower_mode_in = 1'b0;
        repeat (3) @(negedge core_clk);
        check(sleep_request_out, 1'b1);
        @(negedge core_clk);
        check({device_sleep_state, sleep_request_out}, 2'h0);
        repeat (4) @(negedge core_clk);
        leader_sleep(1'b0);
        leader_sleep(1'b1);
        // In the follower role the board holds the low-power input fixed high.
        lowpower_mode_in = 1'b1;
        do_reset(1'b1);
        check(sleep_request_oe, 1'b1);
        check(lowpower_mode_seen, 1'b0);
        force_ack = 1'b1;
        repeat (2) @(negedge core_clk);
        check(device_sleep_state, 1'b0);
        @(negedge core_clk);
        check(device_sleep_state, 1'b1);
        check(sleep_request_out, 1'b0);
        force_ack = 1'b0;
        wake_up();
        end_sim();
    end
endmodule
